// ===== inc/fwpe_pkg.sv
// Shared constants for the flash write-protect, program and erase sequencer.
// Assumes a 512 KiB array of eight 64 KiB sectors behind a byte-wide memory port.
package fwpe_pkg;
    localparam logic [7:0] OP_PROG = 8'h02;
    localparam logic [7:0] OP_ERASE = 8'hd8;
    localparam logic [7:0] OP_WRITE_ENABLE_CMD = 8'h06;
    localparam logic [7:0] OP_WRITE_DISABLE_CMD = 8'h04;
    localparam logic [7:0] OP_STATUS_WRITE_CMD = 8'h01;
    localparam logic [7:0] OP_RDSR = 8'h05;
    localparam int SR_WIP = 0;
    localparam int SR_WEL = 1;
    localparam int SR_BP_LSB = 2;
    localparam int SR_STATUS_WRITE_DISABLE = 7;
    localparam logic STATUS_WRITE_DISABLE_RESET = 1'h0;
    localparam logic [2:0] BP_RESET = 3'h0;
    localparam int ADDR_W = 19;
    localparam int SECT_LSB = 16;
    localparam int PAGE_LSB = 8;
    localparam logic [2:0] IDX_DATA = 3'h4;
    localparam logic [8:0] PAGE_BYTES = 9'h100;
    localparam int CLK_PERIOD_NS = 20;
    localparam int PROGRAM_DURATION_NS = 1500000;
    localparam int ERASE_DURATION_NS = 2000000;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_PROG = 2'b01,
        ST_ERASE = 2'b10
    } fwpe_state_e;
    // Protected sectors are taken from the top of the array downward.
    function automatic logic sector_locked(input logic [2:0] bp, input logic [2:0] sect);
        logic [3:0] n;
        n = 4'h0;
        case (bp)
            3'h0: n = 4'h0;
            3'h1: n = 4'h1;
            3'h2: n = 4'h2;
            3'h3: n = 4'h4;
            default: n = 4'h8;
        endcase
        return ({1'b0, sect} >= (4'h8 - n));
    endfunction
endpackage

// ===== rtl/fwpe_link.sv
// Serial link front end, clocked by the host's serial clock.
// Assumes the serial clock only toggles while chip select is low.
`timescale 1ns/1ps
module fwpe_link (
    input wire logic rst,
    input wire logic sck,
    input wire logic cs_n,
    input wire logic si,
    input wire logic [7:0] status_in,
    output logic [7:0] rx_byte,
    output logic rx_toggle,
    output logic aligned,
    output logic so,
    output logic so_oe_n
);
    logic [2:0] bit_reg;
    logic [6:0] sh_reg;
    logic first_reg;
    logic rdsr_reg;
    logic [7:0] st1_reg;
    logic [7:0] st2_reg;
    logic [7:0] tx_reg;

    always_ff @(posedge sck or posedge cs_n) begin
        if (cs_n) begin
            bit_reg <= 3'h0;
            sh_reg <= 7'h00;
        end else begin
            bit_reg <= bit_reg + 3'h1;
            sh_reg <= {sh_reg[5:0], si};
        end
    end

    always_ff @(posedge sck or posedge cs_n) begin
        if (cs_n) begin
            first_reg <= 1'b1;
            rdsr_reg <= 1'b0;
        end else if (bit_reg == 3'h7) begin
            first_reg <= 1'b0;
            if (first_reg && {sh_reg, si} == fwpe_pkg::OP_RDSR) begin
                rdsr_reg <= 1'b1;
            end
        end
    end

    // The alignment flag survives the frame end so the core can judge the last edge.
    // byte boundary
    always_ff @(posedge sck or posedge rst) begin
        if (rst) begin
            rx_byte <= 8'h00;
            rx_toggle <= 1'b0;
            aligned <= 1'b1;
        end else begin
            aligned <= (bit_reg == 3'h7);
            if (bit_reg == 3'h7) begin
                rx_byte <= {sh_reg, si};
                rx_toggle <= ~rx_toggle;
            end
        end
    end

    // Status flags pass a per-bit two-stage sync on sck; latch and busy bits can change in the same cycle.
    always_ff @(posedge sck or posedge rst) begin
        if (rst) begin
            st1_reg <= 8'h00;
            st2_reg <= 8'h00;
        end else begin
            st1_reg <= status_in;
            st2_reg <= st1_reg;
        end
    end

    always_ff @(negedge sck or posedge cs_n) begin
        if (cs_n) begin
            tx_reg <= 8'h00;
        end else if (bit_reg == 3'h0) begin
            tx_reg <= st2_reg;
        end else begin
            tx_reg <= {tx_reg[6:0], 1'b0};
        end
    end

    assign so = tx_reg[7];
    assign so_oe_n = ~(rdsr_reg & ~cs_n);
endmodule

// ===== rtl/fwpe_top.sv
// Write protection, page program and sector erase core of a serial flash.
// Assumes an asynchronous-read byte memory on mem_addr/mem_rdata, written by mem_we.
//
// Behaviour
// - Hardware protection needs protect pin low and status-write-disable set.
// - Only raising the protect pin leaves hardware protection.
// - Under hardware protection, disable and block-protect bits stay frozen.
// - Otherwise those bits may be rewritten once the enable latch is set.
// - Hardware protection guards only status; unlocked memory stays writable.
// - With protect pin high, only block-protect locking applies.
// - Programming only clears bits, never sets them.
// - Program and erase run only with the enable latch set.
// - Keep last 256 data bytes; overflow programs from page start.
// - Program runs only if select rises on a byte boundary.
// - Program starts at select rise, timed, busy flag held meanwhile.
// - Enable latch clears during every program or erase.
// - Program into a locked page is refused.
// - Erase sets every byte of the sector to all ones.
// - Erase opcode plus three address bytes; any address selects sector.
// - Erase runs only if select rises right after a byte.
// - Erase starts at select rise, timed, busy flag until done.
// - Erase of a locked sector is refused.
// - Enable command sets latch, disable command clears it.
// - Status write clears the latch; bit 0 is busy.
// - Input sampled on rising clock, output shifted on falling clock.
`timescale 1ns/1ps
module fwpe_top #(
    parameter int unsigned PROG_CYCLES = (fwpe_pkg::PROGRAM_DURATION_NS
        + fwpe_pkg::CLK_PERIOD_NS - 1) / fwpe_pkg::CLK_PERIOD_NS,
    parameter int unsigned ERASE_CYCLES = (fwpe_pkg::ERASE_DURATION_NS
        + fwpe_pkg::CLK_PERIOD_NS - 1) / fwpe_pkg::CLK_PERIOD_NS
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic sck,
    input wire logic cs_n,
    input wire logic si,
    output logic so,
    output logic so_oe_n,
    input wire logic write_protect_n,
    output logic [18:0] mem_addr,
    input wire logic [7:0] mem_rdata,
    output logic [7:0] mem_wdata,
    output logic mem_we,
    output logic [7:0] status_out,
    output logic write_in_progress,
    output logic write_enable_latch,
    output logic hardware_protected_mode
);
    fwpe_pkg::fwpe_state_e state_reg;
    logic [3:0] cs_s_reg;
    logic [2:0] tg_s_reg;
    logic [1:0] al_s_reg;
    logic [1:0] wp_s_reg;
    logic [7:0] rx_byte;
    logic rx_toggle;
    logic aligned;
    logic cs_rise;
    logic cs_fall;
    logic byte_ev;
    logic take;
    logic [2:0] idx_reg;
    logic [7:0] op_reg;
    logic [23:0] addr_reg;
    logic [8:0] cnt_reg;
    logic [7:0] wr_reg;
    logic over_reg;
    logic [7:0] ring [256];
    logic status_write_disable;
    logic [2:0] bp_reg;
    logic wel_reg;
    logic [15:0] k_reg;
    logic [1:0] ph_reg;
    logic walk_done_reg;
    logic [31:0] timer_reg;
    logic [18:0] mem_addr_reg;
    logic [7:0] mem_wdata_reg;
    logic mem_we_reg;
    logic exec_ok;
    logic go_write_enable_cmd;
    logic go_write_disable_cmd;
    logic go_status_write_cmd;
    logic go_prog;
    logic go_erase;
    logic locked;
    logic [7:0] col;
    logic [7:0] ring_idx;
    logic [7:0] last_k;

    fwpe_link u_link (
        .rst(rst),
        .sck(sck),
        .cs_n(cs_n),
        .si(si),
        .status_in(status_out),
        .rx_byte(rx_byte),
        .rx_toggle(rx_toggle),
        .aligned(aligned),
        .so(so),
        .so_oe_n(so_oe_n)
    );

    // Chip select gets an extra stage so the last byte event is seen before its rise.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cs_s_reg <= 4'hf;
            tg_s_reg <= 3'h0;
            al_s_reg <= 2'h3;
            wp_s_reg <= 2'h3;
        end else begin
            cs_s_reg <= {cs_s_reg[2:0], cs_n};
            tg_s_reg <= {tg_s_reg[1:0], rx_toggle};
            al_s_reg <= {al_s_reg[0], aligned};
            wp_s_reg <= {wp_s_reg[0], write_protect_n};
        end
    end

    assign cs_rise = cs_s_reg[2] & ~cs_s_reg[3];
    assign cs_fall = ~cs_s_reg[2] & cs_s_reg[3];
    assign byte_ev = tg_s_reg[1] ^ tg_s_reg[2];
    assign take = byte_ev && state_reg == fwpe_pkg::ST_IDLE && !cs_s_reg[2];

    assign hardware_protected_mode = !wp_s_reg[1] && status_write_disable;

    // The received byte is held for eight serial clocks, far longer than the sync delay.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            idx_reg <= 3'h0;
            op_reg <= 8'h00;
            addr_reg <= 24'h000000;
            cnt_reg <= 9'h000;
            wr_reg <= 8'h00;
            over_reg <= 1'b0;
        end else if (cs_fall) begin
            idx_reg <= 3'h0;
            // A frame that opens while busy must not disturb the running program walk.
            if (state_reg == fwpe_pkg::ST_IDLE) begin
                cnt_reg <= 9'h000;
                wr_reg <= 8'h00;
                over_reg <= 1'b0;
            end
        end else if (take) begin
            if (idx_reg == 3'h0) begin
                op_reg <= rx_byte;
            end
            if (idx_reg != fwpe_pkg::IDX_DATA) begin
                idx_reg <= idx_reg + 3'h1;
            end
            if (idx_reg != 3'h0 && idx_reg != fwpe_pkg::IDX_DATA) begin
                addr_reg <= {addr_reg[15:0], rx_byte};
            end
            if (idx_reg == fwpe_pkg::IDX_DATA) begin
                wr_reg <= wr_reg + 8'h01;
                if (cnt_reg == fwpe_pkg::PAGE_BYTES) begin
                    over_reg <= 1'b1;
                end else begin
                    cnt_reg <= cnt_reg + 9'h001;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (take && idx_reg == fwpe_pkg::IDX_DATA) begin
            ring[wr_reg] <= rx_byte;
        end
    end

    always_comb begin
        locked = fwpe_pkg::sector_locked(bp_reg, addr_reg[fwpe_pkg::SECT_LSB +: 3]);
        exec_ok = cs_rise && state_reg == fwpe_pkg::ST_IDLE && al_s_reg[1];
        go_write_enable_cmd = exec_ok && idx_reg == 3'h1 && op_reg == fwpe_pkg::OP_WRITE_ENABLE_CMD;
        go_write_disable_cmd = exec_ok && idx_reg == 3'h1 && op_reg == fwpe_pkg::OP_WRITE_DISABLE_CMD;
        go_status_write_cmd = exec_ok && idx_reg == 3'h2 && op_reg == fwpe_pkg::OP_STATUS_WRITE_CMD && wel_reg
            && !hardware_protected_mode;
        go_prog = exec_ok && idx_reg == fwpe_pkg::IDX_DATA && cnt_reg != 9'h000
            && op_reg == fwpe_pkg::OP_PROG && wel_reg && !locked;
        go_erase = exec_ok && idx_reg == fwpe_pkg::IDX_DATA && cnt_reg == 9'h000
            && op_reg == fwpe_pkg::OP_ERASE && wel_reg && !locked;
    end

    // Status writes commit at select rise with the byte that followed the opcode.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            status_write_disable <= fwpe_pkg::STATUS_WRITE_DISABLE_RESET;
            bp_reg <= fwpe_pkg::BP_RESET;
        end else if (go_status_write_cmd) begin
            status_write_disable <= addr_reg[fwpe_pkg::SR_STATUS_WRITE_DISABLE];
            bp_reg <= addr_reg[fwpe_pkg::SR_BP_LSB +: 3];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wel_reg <= 1'b0;
        end else if (go_write_enable_cmd) begin
            wel_reg <= 1'b1;
        end else if (go_write_disable_cmd || go_status_write_cmd || go_prog || go_erase) begin
            wel_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg <= fwpe_pkg::ST_IDLE;
        end else begin
            case (state_reg)
                fwpe_pkg::ST_IDLE: begin
                    if (go_prog) begin
                        state_reg <= fwpe_pkg::ST_PROG;
                    end else if (go_erase) begin
                        state_reg <= fwpe_pkg::ST_ERASE;
                    end
                end
                fwpe_pkg::ST_PROG, fwpe_pkg::ST_ERASE: begin
                    if (walk_done_reg && timer_reg == 32'h0) begin
                        state_reg <= fwpe_pkg::ST_IDLE;
                    end
                end
                default: state_reg <= fwpe_pkg::ST_IDLE;
            endcase
        end
    end

    // On overflow the oldest kept byte lands at the page start.
    assign col = over_reg ? 8'h00 : addr_reg[7:0];
    assign ring_idx = over_reg ? (wr_reg + k_reg[7:0]) : k_reg[7:0];
    assign last_k = cnt_reg[7:0] - 8'h01;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            k_reg <= 16'h0000;
            ph_reg <= 2'h0;
            walk_done_reg <= 1'b1;
            timer_reg <= 32'h0;
            mem_addr_reg <= 19'h00000;
            mem_wdata_reg <= 8'h00;
            mem_we_reg <= 1'b0;
        end else if (go_prog || go_erase) begin
            k_reg <= 16'h0000;
            ph_reg <= 2'h0;
            walk_done_reg <= 1'b0;
            timer_reg <= go_prog ? PROG_CYCLES - 32'h1 : ERASE_CYCLES - 32'h1;
        end else begin
            if (timer_reg != 32'h0) begin
                timer_reg <= timer_reg - 32'h1;
            end
            mem_we_reg <= 1'b0;
            if (!walk_done_reg && state_reg == fwpe_pkg::ST_PROG) begin
                case (ph_reg)
                    2'h0: begin
                        mem_addr_reg <= {addr_reg[18:8], col + k_reg[7:0]};
                        ph_reg <= 2'h1;
                    end
                    2'h1: begin
                        mem_wdata_reg <= mem_rdata & ring[ring_idx];
                        mem_we_reg <= 1'b1;
                        ph_reg <= 2'h2;
                    end
                    default: begin
                        ph_reg <= 2'h0;
                        if (k_reg[7:0] == last_k) begin
                            walk_done_reg <= 1'b1;
                        end else begin
                            k_reg <= k_reg + 16'h0001;
                        end
                    end
                endcase
            end else if (!walk_done_reg && state_reg == fwpe_pkg::ST_ERASE) begin
                mem_addr_reg <= {addr_reg[18:16], k_reg};
                mem_wdata_reg <= 8'hff;
                mem_we_reg <= 1'b1;
                k_reg <= k_reg + 16'h0001;
                if (k_reg == 16'hffff) begin
                    walk_done_reg <= 1'b1;
                end
            end
        end
    end

    assign mem_addr = mem_addr_reg;
    assign mem_wdata = mem_wdata_reg;
    assign mem_we = mem_we_reg;
    assign write_in_progress = state_reg != fwpe_pkg::ST_IDLE;
    assign write_enable_latch = wel_reg;
    assign status_out = {status_write_disable, 2'h0, bp_reg, wel_reg, write_in_progress};

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    chk_hpm_entry: assert property ($rose(hardware_protected_mode) |->
        !wp_s_reg[1] && status_write_disable)
        else $error("protected mode entered without both conditions");
    chk_hpm_exit: assert property ($fell(hardware_protected_mode) |-> wp_s_reg[1])
        else $error("protected mode left while pin low");
    chk_hpm_frozen: assert property (hardware_protected_mode |=>
        $stable(bp_reg) && $stable(status_write_disable))
        else $error("status bits changed under protection");
    chk_prog_clears: assert property (mem_we && state_reg == fwpe_pkg::ST_PROG |->
        (mem_wdata & ~$past(mem_rdata)) == 8'h00)
        else $error("program set a bit");
    chk_start_latch: assert property ($rose(write_in_progress) |-> $past(wel_reg)
        && $past(cs_rise))
        else $error("operation started without latch or select rise");
    chk_latch_clear: assert property (write_in_progress |-> !wel_reg)
        else $error("latch set during operation");
    chk_wip_hold: assert property ($rose(write_in_progress) |->
        write_in_progress [*8])
        else $error("busy flag dropped early");
    chk_erase_ones: assert property (mem_we && state_reg == fwpe_pkg::ST_ERASE |->
        mem_wdata == 8'hff && mem_addr[18:16] == addr_reg[18:16])
        else $error("erase wrote wrong data or sector");
    chk_lock_obeyed: assert property ($rose(write_in_progress) |->
        !fwpe_pkg::sector_locked(bp_reg, addr_reg[18:16]))
        else $error("locked area started an operation");
    chk_busy_ignore: assert property (byte_ev && write_in_progress |=>
        $stable(idx_reg) && $stable(cnt_reg))
        else $error("byte taken while busy");
endmodule

// ===== test/fwpe_host.sv
// Host model: serial bus master that frames commands on select, sck and si.
// Assumes the core samples si on rising sck and shifts so out on falling sck.
`timescale 1ns/1ps
module fwpe_host (
    output logic sck,
    output logic cs_n,
    output logic si,
    input wire logic so
);
    initial begin
        sck = 1'b0;
        cs_n = 1'b1;
        si = 1'b0;
    end
    task automatic frame_begin();
        cs_n <= 1'b0;
        #16;
    endtask
    task automatic put_bits(input logic [7:0] b, input int n);
        for (int i = 7; i > 7 - n; i--) begin
            si <= b[i];
            #8 sck <= 1'b1;
            #16 sck <= 1'b0;
            #8;
        end
    endtask
    task automatic frame_end();
        #8 cs_n <= 1'b1;
        // A released line must not keep showing its last bit.
        si <= ~si;
        #300;
    endtask
    task automatic rd_status(output logic [7:0] v);
        frame_begin();
        put_bits(fwpe_pkg::OP_RDSR, 8);
        for (int i = 7; i >= 0; i--) begin
            #8 sck <= 1'b1;
            v[i] = so;
            #16 sck <= 1'b0;
            #8;
        end
        frame_end();
    endtask
endmodule

// ===== test/fwpe_top_test.sv
// Self-checking bench for the flash protect, program and erase core.
// Assumes a byte array model on the memory port and the host model on the link.
`timescale 1ns/1ps
module fwpe_top_test;
    logic clk, rst, sck, cs_n, si, so, so_oe_n, write_protect_n, mem_we;
    logic write_in_progress, write_enable_latch, hardware_protected_mode;
    logic [18:0] mem_addr;
    logic [7:0] mem_rdata, mem_wdata, status_out, v;
    logic [7:0] mem [0:524287];
    logic [26:0] exp_q [$];
    int errors = 0;
    int tests_run = 0;
    int seed = 94967;
    fwpe_top #(.PROG_CYCLES(300), .ERASE_CYCLES(70000)) i_fwpe_top (.clk(clk), .rst(rst),
        .sck(sck), .cs_n(cs_n), .si(si), .so(so), .so_oe_n(so_oe_n),
        .write_protect_n(write_protect_n), .mem_addr(mem_addr), .mem_rdata(mem_rdata),
        .mem_wdata(mem_wdata), .mem_we(mem_we), .status_out(status_out),
        .write_in_progress(write_in_progress), .write_enable_latch(write_enable_latch),
        .hardware_protected_mode(hardware_protected_mode));
    fwpe_host i_fwpe_host (.sck(sck), .cs_n(cs_n), .si(si), .so(so));
    assign mem_rdata = mem[mem_addr];
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic summarize();
        if (errors == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic cmp_flag(input string n, input logic [7:0] e, input logic [7:0] g);
        @(negedge clk);
        tests_run++;
        if (g !== e) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic cmp_write(input logic [26:0] e, input logic [26:0] g);
        tests_run++;
        if (g !== e) begin
            errors++;
            $display("CHECK FAILED mem write expected %h seen %h", e, g);
        end
    endtask
    // Writes are matched in order against the notes left by the driver.
    always @(negedge clk) begin
        if (mem_we === 1'b1) begin
            if (exp_q.size() == 0) begin
                cmp_write('x, {mem_addr, mem_wdata});
            end else begin
                cmp_write(exp_q.pop_front(), {mem_addr, mem_wdata});
            end
            mem[mem_addr] = mem_wdata;
        end
    end
    task automatic cmd(input logic [7:0] op, input logic [7:0] d, input int nb);
        i_fwpe_host.frame_begin();
        i_fwpe_host.put_bits(op, 8);
        if (nb > 1) i_fwpe_host.put_bits(d, 8);
        i_fwpe_host.frame_end();
    endtask
    task automatic send_addr(input logic [7:0] op, input logic [18:0] a);
        i_fwpe_host.frame_begin();
        i_fwpe_host.put_bits(op, 8);
        i_fwpe_host.put_bits({5'h0, a[18:16]}, 8);
        i_fwpe_host.put_bits(a[15:8], 8);
        i_fwpe_host.put_bits(a[7:0], 8);
    endtask
    task automatic prog(input logic [18:0] a, input int n, input int extra, input bit ok);
        logic [7:0] d;
        logic [18:0] t;
        int first;
        first = (n > 256) ? n - 256 : 0;
        send_addr(fwpe_pkg::OP_PROG, a);
        for (int j = 0; j < n; j++) begin
            d = 8'($random(seed));
            t = (n > 256) ? {a[18:8], 8'(j - first)} : a + 19'(j);
            if (ok && j >= first) begin
                mem[t] = 8'($random(seed));
                exp_q.push_back({t, mem[t] & d});
            end
            i_fwpe_host.put_bits(d, 8);
        end
        if (extra > 0) i_fwpe_host.put_bits(8'($random(seed)), extra);
        i_fwpe_host.frame_end();
    endtask
    task automatic erase(input logic [18:0] a, input int extra, input bit ok);
        if (ok) begin
            for (int i = 0; i < 65536; i++) exp_q.push_back({a[18:16], 16'(i), 8'hff});
        end
        send_addr(fwpe_pkg::OP_ERASE, a);
        if (extra > 0) i_fwpe_host.put_bits(8'h00, extra);
        i_fwpe_host.frame_end();
    endtask
    task automatic wait_idle();
        int k;
        k = 0;
        while (write_in_progress !== 1'b0 && k < 80000) begin
            @(posedge clk);
            k++;
        end
        repeat (4) @(posedge clk);
        cmp_flag("busy", 8'h00, {7'h0, write_in_progress});
        cmp_flag("pending", 8'h00, {7'h0, exp_q.size() != 0});
    endtask
    task automatic busy_check();
        cmp_flag("wip", 8'h01, {7'h0, write_in_progress});
        cmp_flag("wel", 8'h00, {7'h0, write_enable_latch});
    endtask
    initial begin
        #1_900_000;
        errors++;
        summarize();
    end
    initial begin
        rst = 1'b1;
        write_protect_n = 1'b1;
        foreach (mem[i]) mem[i] = 8'hff;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        cmp_flag("status", 8'h00, status_out);
        cmd(fwpe_pkg::OP_WRITE_ENABLE_CMD, 8'h00, 1);
        cmp_flag("wel", 8'h01, {7'h0, write_enable_latch});
        cmd(fwpe_pkg::OP_WRITE_DISABLE_CMD, 8'h00, 1);
        cmp_flag("wel", 8'h00, {7'h0, write_enable_latch});
        prog({3'h0, 16'($random(seed))}, 1, 0, 0);
        wait_idle();
        cmd(fwpe_pkg::OP_WRITE_ENABLE_CMD, 8'h00, 1);
        prog({3'h0, 16'($random(seed))}, 1, 0, 1);
        busy_check();
        i_fwpe_host.rd_status(v);
        cmp_flag("status busy", 8'h01, v);
        cmp_flag("oe idle", 8'h01, {7'h0, so_oe_n});
        cmd(fwpe_pkg::OP_WRITE_ENABLE_CMD, 8'h00, 1);
        cmp_flag("wel busy", 8'h00, {7'h0, write_enable_latch});
        wait_idle();
        cmd(fwpe_pkg::OP_WRITE_ENABLE_CMD, 8'h00, 1);
        prog({3'h1, 16'($random(seed))}, 258, 0, 1);
        wait_idle();
        cmd(fwpe_pkg::OP_WRITE_ENABLE_CMD, 8'h00, 1);
        prog({3'h2, 16'($random(seed))}, 1, 3, 0);
        erase({3'h2, 16'($random(seed))}, 5, 0);
        wait_idle();
        cmd(fwpe_pkg::OP_WRITE_ENABLE_CMD, 8'h00, 1);
        cmd(fwpe_pkg::OP_STATUS_WRITE_CMD, 8'h84, 2);
        repeat (4) @(posedge clk);
        cmp_flag("hpm", 8'h00, {7'h0, hardware_protected_mode});
        @(posedge clk);
        write_protect_n <= 1'b0;
        repeat (6) @(posedge clk);
        cmp_flag("hpm", 8'h01, {7'h0, hardware_protected_mode});
        cmd(fwpe_pkg::OP_WRITE_ENABLE_CMD, 8'h00, 1);
        cmd(fwpe_pkg::OP_STATUS_WRITE_CMD, 8'h00, 2);
        prog({3'h7, 16'($random(seed))}, 1, 0, 0);
        erase({3'h7, 16'($random(seed))}, 0, 0);
        wait_idle();
        cmp_flag("wel kept", 8'h01, {7'h0, write_enable_latch});
        i_fwpe_host.rd_status(v);
        cmp_flag("status hpm", 8'h86, v);
        prog({3'h3, 16'($random(seed))}, 1, 0, 1);
        wait_idle();
        @(posedge clk);
        write_protect_n <= 1'b1;
        repeat (6) @(posedge clk);
        cmp_flag("hpm", 8'h00, {7'h0, hardware_protected_mode});
        cmd(fwpe_pkg::OP_WRITE_ENABLE_CMD, 8'h00, 1);
        cmd(fwpe_pkg::OP_STATUS_WRITE_CMD, 8'h00, 2);
        cmd(fwpe_pkg::OP_WRITE_DISABLE_CMD, 8'h00, 1);
        i_fwpe_host.rd_status(v);
        cmp_flag("status spm", 8'h00, v);
        cmd(fwpe_pkg::OP_WRITE_ENABLE_CMD, 8'h00, 1);
        erase({3'h2, 16'($random(seed))}, 0, 1);
        busy_check();
        wait_idle();
        summarize();
    end
endmodule
